/* sfp_pkg.sv */
// Shared constants for the serial flash pin front end: register map,
// field positions, reset values, lane modes and link states.
// Assumes a classic Wishbone slave port with 32-bit data and byte addresses.
package sfp_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] SFP_REG_CTRL = 8'h00;
  localparam logic [7:0] SFP_REG_STBITS = 8'h04;
  localparam logic [7:0] SFP_REG_TXDATA = 8'h08;
  localparam logic [7:0] SFP_REG_RXDATA = 8'h0c;
  localparam logic [7:0] SFP_REG_STATE = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SFP_CTRL_MODE_LSB = 0;
  localparam int SFP_CTRL_DRIVE_BIT = 2;
  localparam int SFP_CTRL_PFS_BIT = 3;
  localparam int SFP_CTRL_QCM_BIT = 4;
  localparam int SFP_ST_BP_LSB = 2;
  localparam int SFP_ST_QE_BIT = 6;
  localparam int SFP_ST_SWD_BIT = 7;
  localparam int SFP_STATE_SEL_BIT = 0;
  localparam int SFP_STATE_PAUSE_BIT = 1;
  localparam int SFP_STATE_HWRST_BIT = 2;
  localparam int SFP_STATE_RXFULL_BIT = 3;
  localparam int SFP_STATE_REJ_BIT = 4;
  localparam int SFP_STATE_WP_BIT = 5;
  localparam int SFP_STATE_STBY_BIT = 6;

  // ----------------------------------------------------------------------
  // Reset values and lane modes
  // ----------------------------------------------------------------------
  localparam logic [4:0] SFP_CTRL_RESET = 5'h00;
  localparam logic [7:0] SFP_STBITS_RESET = 8'h00;
  localparam logic [7:0] SFP_TXDATA_RESET = 8'hff;
  localparam logic [1:0] SFP_MODE_SINGLE = 2'h0;
  localparam logic [1:0] SFP_MODE_DUAL = 2'h1;
  localparam logic [1:0] SFP_MODE_QUAD = 2'h2;
  localparam logic [3:0] SFP_BITS_PER_BYTE = 4'h8;
  localparam int SFP_SYNC_W = 6;

  // Link states.
  typedef enum logic [1:0] {SFP_LNK_IDLE, SFP_LNK_ACTIVE, SFP_LNK_PAUSED, SFP_LNK_HWRST} sfp_lnk_e;

  // Number of lanes that carry one beat in the given mode.
  function automatic logic [3:0] sfp_lane_count(input logic [1:0] mode);
    case (mode)
      SFP_MODE_DUAL: sfp_lane_count = 4'h2;
      SFP_MODE_QUAD: sfp_lane_count = 4'h4;
      default: sfp_lane_count = 4'h1;
    endcase
  endfunction

endpackage

/* sfp_sync.sv */
// Two-flop synchroniser for a group of independent pin levels.
// Assumes each bit is a slow level or a clock far below clk_i.
`timescale 1ns/10ps
module sfp_sync
  import sfp_pkg::*;
#(
  parameter int W = SFP_SYNC_W
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // ----------------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------------
  // The first stage feeds only the second stage.
  // Reset loads rst_val_i into both stages; the output keeps that level until async_i has passed both flops.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= rst_val_i;
      sync_r <= rst_val_i;
    end
    else
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  // Only the second stage is seen by the rest of the block.
  assign sync_o = sync_r;

endmodule

/* sfp_pin_frontend.sv */
// Pin-level front end of a serial flash: select, pause, hardware reset,
// lane direction and bit shifting, with a classic Wishbone register port.
// Assumes all pins are asynchronous to clk_i and the serial clock is well
// below a quarter of clk_i; instruction decoding sits outside this block.
//
// Summary of operation
// - Select high floats outputs, enters standby.
// - Select high ignores input; low selects.
// - Instruction accepted only after select high-to-low.
// - Single mode samples lane 0 on rising edges.
// - Single mode drives lane 1 on falling edges.
// - Dual/quad lanes bidirectional; rise in, fall out.
// - Quad uses protect and pause pins as lanes 2,3.
// - Disable bit set, protect low rejects status writes.
// - Disable bit clear always allows status writes.
// - Quad enable removes write protect pin function.
// - Fourth pin: lane 3, pause or reset.
// - Pause suspends transfer, floats output, keeps state.
// - Reset input low holds reset, outputs float.
// - Both clock idle polarities work identically.
// - Quad mode makes all four pins lanes.
`timescale 1ns/10ps
module sfp_pin_frontend
  import sfp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  // Flash pins.
  input wire logic sck_i,
  input wire logic sel_n_i,
  input wire logic [3:0] lane_i,
  output logic [3:0] lane_o,
  output logic [3:0] lane_oe_o,
  output logic standby_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [SFP_SYNC_W-1:0] pin_sync;
  logic sck_s;
  logic sel_n_s;
  logic [3:0] lane_s;
  logic sck_prev_r;
  logic sel_n_prev_r;
  logic sck_rise;
  logic sck_fall;
  logic sel_fall;
  sfp_lnk_e lnk_r;
  sfp_lnk_e lnk_nxt;
  logic [4:0] ctrl_r;
  logic [7:0] stbits_r;
  logic [7:0] tx_data_r;
  logic [7:0] rx_data_r;
  logic [7:0] rx_shift_r;
  logic [7:0] tx_shift_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] tx_cnt_r;
  logic rise_seen_r;
  logic rx_full_r;
  logic rej_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic quad_en;
  logic pin_func;
  logic pause_lvl;
  logic hwrst_lvl;
  logic protect;
  logic [1:0] eff_mode;
  logic [3:0] nlanes;
  logic byte_done;
  logic wb_req;
  logic wb_wr;
  logic wb_rd;
  logic drive_ok;

  // ----------------------------------------------------------------------
  // Pin synchronisers and serial clock edge detection
  // ----------------------------------------------------------------------
  // Every pin passes two flops before any logic looks at it.
  sfp_sync #(
    .W(SFP_SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({lane_i, sel_n_i, sck_i}),
    .rst_val_i({4'hf, 1'b0, 1'b0}),
    .sync_o(pin_sync)
  );

  assign sck_s = pin_sync[0];
  assign sel_n_s = pin_sync[1];
  assign lane_s = pin_sync[5:2];

  // Previous levels for edge detection; select starts low so a high must be seen first.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sck_prev_r <= 1'b0;
      sel_n_prev_r <= 1'b0;
    end
    else
    begin
      sck_prev_r <= sck_s;
      sel_n_prev_r <= sel_n_s;
    end
  end

  // Edges are taken the same way whichever level the clock idles at.
  assign sck_rise = sck_s & ~sck_prev_r;
  assign sck_fall = ~sck_s & sck_prev_r;
  assign sel_fall = sel_n_prev_r & ~sel_n_s;

  // ----------------------------------------------------------------------
  // Pin function decoding
  // ----------------------------------------------------------------------
  // The fourth pin is a lane when quad is enabled, else pause or reset.
  assign quad_en = stbits_r[SFP_ST_QE_BIT];
  assign pin_func = ctrl_r[SFP_CTRL_PFS_BIT];
  assign pause_lvl = ~quad_en & ~pin_func & ~lane_s[3] & ~sel_n_s;
  assign hwrst_lvl = ~quad_en & pin_func & ~lane_s[3];

  // Protect pin only counts with quad off and the disable bit set.
  assign protect = stbits_r[SFP_ST_SWD_BIT] & ~lane_s[2] & ~quad_en;

  // Quad lanes need quad enabled; command mode forces quad lanes.
  always_comb
  begin
    eff_mode = SFP_MODE_SINGLE;
    if (quad_en && (ctrl_r[SFP_CTRL_QCM_BIT] || ctrl_r[1:0] == SFP_MODE_QUAD))
    begin
      eff_mode = SFP_MODE_QUAD;
    end
    else if (ctrl_r[1:0] == SFP_MODE_DUAL)
    begin
      eff_mode = SFP_MODE_DUAL;
    end
  end

  assign nlanes = sfp_lane_count(eff_mode);

  // ----------------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------------
  // Reset has top priority; leaving idle takes a select falling edge.
  always_comb
  begin
    lnk_nxt = lnk_r;
    case (lnk_r)
      SFP_LNK_IDLE:
      begin
        if (sel_fall)
        begin
          lnk_nxt = SFP_LNK_ACTIVE;
        end
      end
      SFP_LNK_ACTIVE:
      begin
        if (sel_n_s)
        begin
          lnk_nxt = SFP_LNK_IDLE;
        end
        else if (pause_lvl)
        begin
          lnk_nxt = SFP_LNK_PAUSED;
        end
      end
      SFP_LNK_PAUSED:
      begin
        if (sel_n_s)
        begin
          lnk_nxt = SFP_LNK_IDLE;
        end
        else if (!pause_lvl)
        begin
          lnk_nxt = SFP_LNK_ACTIVE;
        end
      end
      SFP_LNK_HWRST:
      begin
        lnk_nxt = SFP_LNK_IDLE;
      end
      default:
      begin
        lnk_nxt = SFP_LNK_IDLE;
      end
    endcase
    if (hwrst_lvl)
    begin
      lnk_nxt = SFP_LNK_HWRST;
    end
  end

  // State register.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lnk_r <= SFP_LNK_IDLE;
    end
    else
    begin
      lnk_r <= lnk_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Receive shifter
  // ----------------------------------------------------------------------
  assign byte_done = (lnk_r == SFP_LNK_ACTIVE) && sck_rise && (rx_cnt_r + nlanes >= SFP_BITS_PER_BYTE);

  // Bits enter on rising edges only while active, never while paused.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || lnk_r == SFP_LNK_IDLE || lnk_r == SFP_LNK_HWRST)
    begin
      rx_shift_r <= 8'h00;
      rx_cnt_r <= 4'h0;
    end
    else if (lnk_r == SFP_LNK_ACTIVE && sck_rise)
    begin
      case (eff_mode)
        SFP_MODE_DUAL: rx_shift_r <= {rx_shift_r[5:0], lane_s[1:0]};
        SFP_MODE_QUAD: rx_shift_r <= {rx_shift_r[3:0], lane_s[3:0]};
        default: rx_shift_r <= {rx_shift_r[6:0], lane_s[0]};
      endcase
      rx_cnt_r <= byte_done ? 4'h0 : rx_cnt_r + nlanes;
    end
  end

  // Completed byte is held for software.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_data_r <= 8'h00;
    end
    else if (byte_done)
    begin
      case (eff_mode)
        SFP_MODE_DUAL: rx_data_r <= {rx_shift_r[5:0], lane_s[1:0]};
        SFP_MODE_QUAD: rx_data_r <= {rx_shift_r[3:0], lane_s[3:0]};
        default: rx_data_r <= {rx_shift_r[6:0], lane_s[0]};
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Transmit shifter
  // ----------------------------------------------------------------------
  // First beat is preloaded at select so that an idle-high clock's first
  // falling edge does not shift before any rising edge has been seen.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_shift_r <= SFP_TXDATA_RESET;
      tx_cnt_r <= 4'h0;
      rise_seen_r <= 1'b0;
    end
    else if (lnk_r == SFP_LNK_IDLE || lnk_r == SFP_LNK_HWRST)
    begin
      tx_shift_r <= tx_data_r;
      tx_cnt_r <= 4'h0;
      rise_seen_r <= 1'b0;
    end
    else if (lnk_r == SFP_LNK_ACTIVE)
    begin
      if (sck_rise)
      begin
        rise_seen_r <= 1'b1;
      end
      if (sck_fall && rise_seen_r)
      begin
        if (tx_cnt_r + nlanes >= SFP_BITS_PER_BYTE)
        begin
          tx_shift_r <= tx_data_r;
          tx_cnt_r <= 4'h0;
        end
        else
        begin
          tx_shift_r <= (tx_shift_r << nlanes[2:0]);
          tx_cnt_r <= tx_cnt_r + nlanes;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Lane drivers
  // ----------------------------------------------------------------------
  // Drive only while selected, unpaused, out of reset and software asks.
  // The pin levels also gate directly, so lanes float in the cycle before the state moves.
  assign drive_ok = (lnk_r == SFP_LNK_ACTIVE) && !sel_n_s && !pause_lvl && !hwrst_lvl &&
                    ctrl_r[SFP_CTRL_DRIVE_BIT];

  // Lane data comes straight from the shift register flops.
  always_comb
  begin
    lane_o = 4'h0;
    lane_oe_o = 4'h0;
    case (eff_mode)
      SFP_MODE_DUAL:
      begin
        lane_o = {2'b00, tx_shift_r[7:6]};
        lane_oe_o = {2'b00, drive_ok, drive_ok};
      end
      SFP_MODE_QUAD:
      begin
        lane_o = tx_shift_r[7:4];
        lane_oe_o = {4{drive_ok}};
      end
      default:
      begin
        lane_o = {2'b00, tx_shift_r[7], 1'b0};
        lane_oe_o = {2'b00, drive_ok, 1'b0};
      end
    endcase
  end

  assign standby_o = sel_n_s;

  // ----------------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------------
  assign wb_req = cyc_i & stb_i;
  assign wb_wr = wb_req & we_i & ack_r & sel_i[0];
  assign wb_rd = wb_req & ~we_i & ack_r;

  // Ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= wb_req & ~ack_r;
    end
  end

  // Read data is captured with the request so it stands with ack.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_r <= 32'h0;
    end
    else if (wb_req && !ack_r)
    begin
      case (adr_i)
        SFP_REG_CTRL: dat_r <= {27'h0, ctrl_r};
        SFP_REG_STBITS: dat_r <= {24'h0, stbits_r};
        SFP_REG_TXDATA: dat_r <= {24'h0, tx_data_r};
        SFP_REG_RXDATA: dat_r <= {24'h0, rx_data_r};
        SFP_REG_STATE:
        begin
          dat_r <= 32'h0;
          dat_r[SFP_STATE_SEL_BIT] <= (lnk_r == SFP_LNK_ACTIVE) || (lnk_r == SFP_LNK_PAUSED);
          dat_r[SFP_STATE_PAUSE_BIT] <= (lnk_r == SFP_LNK_PAUSED);
          dat_r[SFP_STATE_HWRST_BIT] <= (lnk_r == SFP_LNK_HWRST);
          dat_r[SFP_STATE_RXFULL_BIT] <= rx_full_r;
          dat_r[SFP_STATE_REJ_BIT] <= rej_r;
          dat_r[SFP_STATE_WP_BIT] <= lane_s[2];
          dat_r[SFP_STATE_STBY_BIT] <= sel_n_s;
        end
        default: dat_r <= 32'h0;
      endcase
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Control and transmit data writes.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= SFP_CTRL_RESET;
      tx_data_r <= SFP_TXDATA_RESET;
    end
    else if (wb_wr)
    begin
      if (adr_i == SFP_REG_CTRL)
      begin
        ctrl_r <= dat_i[4:0];
      end
      if (adr_i == SFP_REG_TXDATA)
      begin
        tx_data_r <= dat_i[7:0];
      end
    end
  end

  // Status bits are written only when the protect condition is absent.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stbits_r <= SFP_STBITS_RESET;
    end
    else if (wb_wr && adr_i == SFP_REG_STBITS && !protect)
    begin
      stbits_r <= {dat_i[7:2], 2'b00};
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_full_r <= 1'b0;
      rej_r <= 1'b0;
    end
    else
    begin
      if (byte_done)
      begin
        rx_full_r <= 1'b1;
      end
      else if (wb_rd && adr_i == SFP_REG_RXDATA)
      begin
        rx_full_r <= 1'b0;
      end
      if (wb_wr && adr_i == SFP_REG_STBITS && protect)
      begin
        rej_r <= 1'b1;
      end
      else if (wb_wr && adr_i == SFP_REG_STATE && dat_i[SFP_STATE_REJ_BIT])
      begin
        rej_r <= 1'b0;
      end
    end
  end

endmodule

/* sfp_pin_frontend_sva.sv */
// Checker for the serial flash pin front end, bound to its ports.
// Assumes clk_i is the only clock and rst_i is synchronous.
`timescale 1ns/10ps
module sfp_pin_frontend_sva
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire logic sck_i,
  input wire logic sel_n_i,
  input wire logic [3:0] lane_o,
  input wire logic [3:0] lane_oe_o,
  input wire logic standby_o
);
  logic sck_d_r;
  logic sel_d_r;
  logic [3:0] quiet_r;

  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Counts cycles since a serial clock fall or a select change.
  always_ff @(posedge clk_i)
  begin
    sck_d_r <= sck_i;
    sel_d_r <= sel_n_i;
    if (rst_i || (sck_d_r && !sck_i) || sel_d_r != sel_n_i)
      quiet_r <= 4'h0;
    else if (quiet_r != 4'hf)
      quiet_r <= quiet_r + 4'h1;
  end

  // --------
  // Checks
  // --------
  a_ack_one_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_prompt: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_read_upper_zero: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_standby_float: assert property (standby_o |-> lane_oe_o == 4'h0)
    else $error("lanes driven in standby");
  a_deselect_standby: assert property (sel_n_i [*5] |-> standby_o)
    else $error("no standby while deselected");
  a_select_wakes: assert property (!sel_n_i [*5] |-> !standby_o)
    else $error("standby while selected");
  a_lane_on_fall: assert property ($changed(lane_o) && lane_oe_o != 4'h0 && $past(lane_oe_o) != 4'h0 |-> quiet_r <= 4'h5)
    else $error("lane output moved away from a falling edge");

  c_write: cover property (ack_o && we_i);
  c_quad_drive: cover property (lane_oe_o == 4'hf);
  c_wake: cover property ($fell(standby_o));
endmodule

bind sfp_pin_frontend sfp_pin_frontend_sva sfp_pin_frontend_sva_inst
(
  .clk_i(clk_i), .rst_i(rst_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o),
  .sck_i(sck_i), .sel_n_i(sel_n_i), .lane_o(lane_o), .lane_oe_o(lane_oe_o), .standby_o(standby_o)
);

/* sfp_host.sv */
// Host controller model: drives select, serial clock and lanes.
// Assumes the bench resolves each pin from the device enable.
`timescale 1ns/10ps
module sfp_host
(
  input wire logic [3:0] pin_i,
  output logic sck_o,
  output logic sel_n_o,
  output logic [3:0] host_o
);
  logic [3:0] en_r;
  logic [3:0] dat_r;
  logic wp_r;
  logic hold_r;
  logic tgl_r;

  // Released lanes 0 and 1 toggle so a stale value never looks valid; lanes 2 and 3 carry the protect and pause levels.
  assign host_o = (en_r & dat_r) | (~en_r & {hold_r, wp_r, tgl_r, tgl_r});

  // Idle pins: deselected, protect and pause levels high.
  initial
  begin
    sck_o = 1'b0;
    sel_n_o = 1'b1;
    en_r = 4'h0;
    dat_r = 4'h0;
    wp_r = 1'b1;
    hold_r = 1'b1;
    tgl_r = 1'b0;
  end

  // Free pattern for released lanes.
  always #10 tgl_r = ~tgl_r;

  // Sets the protect and pause or reset levels; never during a write.
  task automatic set_pins(input logic wp, input logic hold);
    wp_r = wp;
    hold_r = hold;
    #43;
  endtask

  // Parks the clock at its idle level, then pulls select low.
  task automatic sel(input logic cpol);
    #3;
    sck_o = cpol;
    #40;
    sel_n_o = 1'b0;
    #100;
  endtask

  // Releases the lanes and deselects after the last edge.
  task automatic desel();
    #40;
    en_r = 4'h0;
    sel_n_o = 1'b1;
    #40;
  endtask

  // Shifts nb beats MSB first: data set at a fall, taken at the rise.
  task automatic xfer(input logic cpol, input int nl, input int nb, input logic rd,
                      input logic [7:0] tx, output logic [7:0] rx);
    logic [3:0] m;
    logic [7:0] t;
    m = 4'hf >> (4 - nl);
    rx = 8'h0;
    t = tx;
    for (int i = 0; i < nb; i++)
    begin
      if (cpol || i > 0)
        sck_o = 1'b0;
      en_r = rd ? 4'h0 : m;
      dat_r = 4'(t >> (8 - nl));
      t = 8'(t << nl);
      #40;
      sck_o = 1'b1;
      rx = 8'((rx << nl) | ((nl == 1) ? {7'h0, pin_i[1]} : {4'h0, pin_i & m}));
      #40;
    end
    if (!cpol)
      sck_o = 1'b0;
  endtask

  // One whole byte in its own select frame.
  task automatic frame(input logic cpol, input int nl, input logic rd, input logic [7:0] tx, output logic [7:0] rx);
    sel(cpol);
    xfer(cpol, nl, 8 / nl, rd, tx, rx);
    desel();
  endtask
endmodule

/* sfp_pin_frontend_tb.sv */
// Self-checking bench for the serial flash pin front end.
// Assumes the host model and the bound checker compile beforehand.
`timescale 1ns/10ps
module sfp_pin_frontend_tb
  import sfp_pkg::*;
();
  logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, sck_i, sel_n_i, standby_o;
  logic [7:0] adr_i;
  logic [31:0] dat_i, dat_o;
  logic [3:0] sel_i, lane_i, lane_o, lane_oe_o, host_lane;
  int error_cnt = 0;
  int n_tests = 0;

  sfp_pin_frontend sfp_pin_frontend_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .sck_i(sck_i),
    .sel_n_i(sel_n_i), .lane_i(lane_i), .lane_o(lane_o), .lane_oe_o(lane_oe_o), .standby_o(standby_o));
  sfp_host sfp_host_inst (.pin_i(lane_i), .sck_o(sck_i), .sel_n_o(sel_n_i), .host_o(host_lane));

  // A lane carries the device level while it drives, else the host level.
  assign lane_i = (lane_oe_o & lane_o) | (~lane_oe_o & host_lane);

  // ----------------
  // Bus and checks
  // ----------------
  // Compares and counts; reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle, held until ack is seen at an edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  // Prints the verdict and stops.
  task automatic final_report();
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_reset();
    // Select passes two flops before standby shows it.
    repeat (3) @(posedge clk_i);
    chk(standby_o, 1'b1);
    chk(lane_oe_o, 4'h0);
    rd(SFP_REG_CTRL, {27'h0, SFP_CTRL_RESET});
    rd(SFP_REG_STBITS, {24'h0, SFP_STBITS_RESET});
    rd(SFP_REG_TXDATA, {24'h0, SFP_TXDATA_RESET});
    wr(8'h1c, 32'hff);
    rd(8'h1c, 32'h0);
    rd(SFP_REG_STATE, 32'h40, 32'h41);
  endtask

  // Every lane mode in both idle polarities, host to device and back.
  task automatic t_lanes();
    logic [7:0] rx, v;
    wr(SFP_REG_STBITS, 32'h40);
    wr(SFP_REG_TXDATA, 32'ha5);
    for (int m = 0; m < 3; m++)
      for (int c = 0; c < 2; c++)
      begin
        v = 8'h3c + 8'(m * 2 + c);
        wr(SFP_REG_CTRL, m);
        sfp_host_inst.frame(c[0], 1 << m, 1'b0, v, rx);
        rd(SFP_REG_STATE, 32'h8, 32'h8);
        rd(SFP_REG_RXDATA, {24'h0, v});
        wr(SFP_REG_CTRL, m | 4);
        sfp_host_inst.frame(c[0], 1 << m, 1'b1, 8'h0, rx);
        chk(rx, 8'ha5);
      end
    // Command mode forces four lanes even with the lane mode field at single.
    wr(SFP_REG_CTRL, 32'h10);
    sfp_host_inst.frame(1'b0, 4, 1'b0, 8'h96, rx);
    rd(SFP_REG_RXDATA, 32'h96);
    wr(SFP_REG_CTRL, 32'h0);
    wr(SFP_REG_STBITS, 32'h0);
  endtask

  task automatic t_protect();
    wr(SFP_REG_STBITS, 32'h80);
    sfp_host_inst.set_pins(1'b0, 1'b1);
    wr(SFP_REG_STBITS, 32'h3c);
    rd(SFP_REG_STBITS, 32'h80);
    rd(SFP_REG_STATE, 32'h10, 32'h10);
    wr(SFP_REG_STATE, 32'h10);
    rd(SFP_REG_STATE, 32'h0, 32'h10);
    sfp_host_inst.set_pins(1'b1, 1'b1);
    wr(SFP_REG_STBITS, 32'hbc);
    rd(SFP_REG_STBITS, 32'hbc);
    wr(SFP_REG_STBITS, 32'h00);
    sfp_host_inst.set_pins(1'b0, 1'b1);
    wr(SFP_REG_STBITS, 32'h3c);
    rd(SFP_REG_STBITS, 32'h3c);
    wr(SFP_REG_STBITS, 32'hc0);
    wr(SFP_REG_STBITS, 32'hc4);
    rd(SFP_REG_STBITS, 32'hc4);
    wr(SFP_REG_STBITS, 32'h0);
    sfp_host_inst.set_pins(1'b1, 1'b1);
  endtask

  // A byte split by a pause with clocks toggled meanwhile.
  task automatic t_pause();
    logic [7:0] rx;
    wr(SFP_REG_CTRL, 32'h4);
    sfp_host_inst.sel(1'b0);
    sfp_host_inst.xfer(1'b0, 1, 4, 1'b0, 8'hc3, rx);
    sfp_host_inst.set_pins(1'b1, 1'b0);
    chk(lane_oe_o, 4'h0);
    rd(SFP_REG_STATE, 32'h2, 32'h2);
    sfp_host_inst.xfer(1'b0, 1, 4, 1'b0, 8'hff, rx);
    sfp_host_inst.set_pins(1'b1, 1'b1);
    sfp_host_inst.xfer(1'b0, 1, 4, 1'b0, 8'h30, rx);
    sfp_host_inst.desel();
    rd(SFP_REG_RXDATA, 32'hc3);
  endtask

  task automatic t_hwrst();
    wr(SFP_REG_CTRL, 32'hc);
    sfp_host_inst.sel(1'b0);
    sfp_host_inst.set_pins(1'b1, 1'b0);
    rd(SFP_REG_STATE, 32'h4, 32'h6);
    chk(lane_oe_o, 4'h0);
    sfp_host_inst.set_pins(1'b1, 1'b1);
    sfp_host_inst.desel();
    wr(SFP_REG_STBITS, 32'h40);
    sfp_host_inst.sel(1'b0);
    sfp_host_inst.set_pins(1'b1, 1'b0);
    rd(SFP_REG_STATE, 32'h1, 32'h7);
    sfp_host_inst.set_pins(1'b1, 1'b1);
    sfp_host_inst.desel();
  endtask

  // Free-running system clock.
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Hang guard well beyond the expected run.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    final_report();
  end

  // Main sequence.
  initial
  begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h0;
    dat_i = 32'h0;
    sel_i = 4'hf;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_lanes();
    t_protect();
    t_pause();
    t_hwrst();
    final_report();
  end
endmodule
